// file: fspr_pkg.sv
package fspr_pkg;

    // Core clock, derived cycle counts, block and frame sizes
    localparam int CORE_PERIOD_NS    = 100;
    localparam int RESET_LOW_NS      = 1000;
    localparam int RESET_LOW_CYCLES  = (RESET_LOW_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int SR_WRITE_NS       = 5000;
    localparam int SR_WRITE_CYCLES   = SR_WRITE_NS / CORE_PERIOD_NS;
    localparam int BLOCK_W           = 9;
    localparam int FRAME_BYTES       = 6;
    localparam int FRAME_BITS_MAX    = FRAME_BYTES * 8;

    // Command codes
    localparam logic [7:0] CMD_LATCH_SET    = 8'h06;
    localparam logic [7:0] CMD_LATCH_CLR    = 8'h04;
    localparam logic [7:0] CMD_READ_SR1     = 8'h05;
    localparam logic [7:0] CMD_READ_SR2     = 8'h35;
    localparam logic [7:0] CMD_READ_SR3     = 8'h15;
    localparam logic [7:0] CMD_STATUS_W12   = 8'h01;
    localparam logic [7:0] CMD_STATUS_W2    = 8'h31;
    localparam logic [7:0] CMD_STATUS_W3    = 8'h11;
    localparam logic [7:0] CMD_PAGE_WRITE   = 8'h02;
    localparam logic [7:0] CMD_SMALL_WIPE   = 8'h20;
    localparam logic [7:0] CMD_LARGE_WIPE   = 8'hd8;
    localparam logic [7:0] CMD_CHIP_WIPE    = 8'h60;
    localparam logic [7:0] CMD_CHIP_WIPE_B  = 8'hc7;
    localparam logic [7:0] CMD_PAUSE        = 8'h75;
    localparam logic [7:0] CMD_CONTINUE     = 8'h7a;
    localparam logic [7:0] CMD_CLEAR_FLAGS  = 8'h30;
    localparam logic [7:0] CMD_ADDR4_ENTER  = 8'hb7;
    localparam logic [7:0] CMD_ADDR4_EXIT   = 8'he9;
    localparam logic [7:0] CMD_RST_ARM      = 8'h66;
    localparam logic [7:0] CMD_RST_GO       = 8'h99;
    localparam logic [7:0] CMD_OTP_PFX1     = 8'haa;
    localparam logic [7:0] CMD_OTP_PFX2     = 8'h55;

    // Field positions, status_protect_reg
    localparam int SR1_BUSY      = 0;
    localparam int SR1_LATCH     = 1;
    localparam int SR1_GUARD_LSB = 2;
    localparam int SR1_LOCK_LO   = 7;
    // status_mode_reg
    localparam int SR2_LOCK_HI   = 0;
    localparam int SR2_QUAD      = 1;
    localparam int SR2_PROG_P    = 2;
    localparam int SR2_ADDR_W    = 3;
    localparam int SR2_SEC_LO    = 4;
    localparam int SR2_SEC_HI    = 5;
    localparam int SR2_INVERT    = 6;
    localparam int SR2_ERASE_P   = 7;
    // status_config_reg
    localparam int SR3_DUMMY_LSB = 0;
    localparam int SR3_PFAIL     = 2;
    localparam int SR3_EFAIL     = 3;
    localparam int SR3_PU_ADDR   = 4;
    localparam int SR3_DRV_LSB   = 5;
    localparam int SR3_PIN_SEL   = 7;

    // Host-writable masks, sticky one-time mask and reset values
    localparam logic [7:0] SR1_WMASK  = 8'hfc;
    localparam logic [7:0] SR2_WMASK  = 8'h73;
    localparam logic [7:0] SR2_OTP    = 8'h30;
    localparam logic [7:0] SR3_WMASK  = 8'hf3;
    localparam logic [7:0] SR1_RESET  = 8'h00;
    localparam logic [7:0] SR2_RESET  = 8'h00;
    localparam logic [7:0] SR3_RESET  = 8'h20;

    typedef enum logic [2:0] {
        OP_NONE, OP_PROG, OP_SMALL, OP_LARGE, OP_CHIP, OP_SUSPEND, OP_RESUME, OP_ABORT
    } fspr_op_e;

    typedef enum logic [1:0] {PFX_IDLE, PFX_AA, PFX_55, PFX_66} fspr_pfx_e;

    typedef struct packed {
        logic                valid;
        fspr_op_e            op;
        logic [BLOCK_W-1:0]  block;
    } fspr_array_cmd_s;

endpackage

// file: fspr_sync.sv
module fspr_sync import fspr_pkg::*; #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    input  wire logic [W-1:0] d_in,
    output logic [W-1:0]      q_out
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            meta  <= INIT;
            q_out <= INIT;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule // fspr_sync

// file: fspr_regs.sv
module fspr_regs import fspr_pkg::*; (
    input  wire logic          core_clk_in,
    input  wire logic          rstn_in,
    input  wire logic          sclk_in,
    input  wire logic          cs_n_in,
    input  wire logic          si_in,
    input  wire logic          wp_n_in,
    input  wire logic          pause_rst_n_in,
    input  wire logic          array_done_in,
    input  wire logic          array_fail_in,
    output logic               so_out,
    output logic               so_oe_out,
    output fspr_array_cmd_s    array_cmd_out,
    output logic               busy_flag_out,
    output logic               quad_lines_on_out,
    output logic               pause_active_out,
    output logic [3:0]         dummy_quad_out,
    output logic [3:0]         dummy_dtr_out,
    output logic [1:0]         out_strength_out,
    output logic               addr_width_flag_out,
    output logic [1:0]         secreg_locked_out
);

    function automatic logic region_guarded(input logic [BLOCK_W-1:0] blk, input logic [4:0] bp,
                                            input logic inv);
        logic [9:0] size;
        logic       hit;
        size = 10'h001 << (bp[3:0] - 4'h1);
        if (bp[3:0] == 4'h0) begin
            hit = 1'b0;
        end else if (bp[3] && (bp[2] || bp[1])) begin
            hit = 1'b1;
        end else if (bp[4]) begin
            hit = ({1'b0, blk} < size);
        end else begin
            hit = ({1'b0, blk} >= (10'h200 - size));
        end
        return hit ^ inv;
    endfunction

    function automatic logic [3:0] dummy_cycles(input logic [1:0] dc, input logic dtr);
        logic [3:0] n;
        n = 4'ha;
        if (dtr) begin
            n = (dc == 2'b01) ? 4'h8 : 4'ha;
        end else begin
            case (dc)
                2'b10:   n = 4'h8;
                2'b11:   n = 4'ha;
                default: n = 4'h6;
            endcase
        end
        return n;
    endfunction

    // Link side, runs only while the host clocks a frame
    logic                       link_clr;
    logic                       fresh;
    logic                       frame_id;
    logic [5:0]                 bit_cnt;
    logic [7:0]                 shreg;
    logic [7:0]                 frame_byte [0:FRAME_BYTES-1];
    logic [23:0]                stat_pub;
    logic [23:0]                stat_meta;
    logic [23:0]                stat_link;
    wire  logic [5:0]           cur_pos  = fresh ? 6'h00 : bit_cnt;
    wire  logic [5:0]           next_pos = (cur_pos == 6'(FRAME_BITS_MAX)) ? cur_pos : cur_pos + 6'h01;
    wire  logic [7:0]           rd_cmd   = frame_byte[0];
    wire  logic                 rd_sel1  = (rd_cmd == CMD_READ_SR1);
    wire  logic                 rd_sel2  = (rd_cmd == CMD_READ_SR2);
    wire  logic                 rd_sel3  = (rd_cmd == CMD_READ_SR3);
    wire  logic                 rd_on    = (bit_cnt >= 6'h08) && (rd_sel1 || rd_sel2 || rd_sel3);
    wire  logic [7:0]           rd_byte  = rd_sel3 ? stat_link[23:16] : rd_sel2 ? stat_link[15:8] : stat_link[7:0];

    // Set while deselected so the first edge of a frame restarts the count
    always_ff @(posedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) fresh <= 1'b1;
        else         fresh <= 1'b0;
    end

    always_ff @(posedge sclk_in or posedge link_clr) begin
        if (link_clr)   frame_id <= 1'b0;
        else if (fresh) frame_id <= ~frame_id;
    end

    // Bytes and count stay frozen after the frame, which is what lets the core read them
    always_ff @(posedge sclk_in) begin
        shreg   <= {shreg[6:0], si_in};
        bit_cnt <= next_pos;
        if (cur_pos[2:0] == 3'h7 && cur_pos < 6'(FRAME_BITS_MAX)) begin
            frame_byte[cur_pos[5:3]] <= {shreg[6:0], si_in};
        end
    end

    // Status is re-sampled on each rising link edge; it settles during the command byte
    always_ff @(posedge sclk_in) begin
        stat_meta <= stat_pub;
        stat_link <= stat_meta;
    end

    always_ff @(negedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            so_out    <= 1'b0;
            so_oe_out <= 1'b0;
        end else begin
            so_out    <= rd_on & rd_byte[~bit_cnt[2:0]];
            so_oe_out <= rd_on;
        end
    end

    // Core side
    logic [3:0]                 sync_q;
    logic                       cs_prev;
    logic                       seen_id;
    logic [7:0]                 sr1_nv;
    logic [7:0]                 sr2_nv;
    logic [7:0]                 sr3_nv;
    logic                       otp_locked;
    logic                       latch;
    logic                       op_running;
    fspr_op_e                   cur_op;
    logic [7:0]                 srw_cnt;
    logic                       erase_paused;
    logic                       program_paused;
    logic                       prog_fail;
    logic                       erase_fail;
    logic                       addr4;
    logic [3:0]                 rst_cnt;
    fspr_pfx_e                  pfx;
    fspr_pfx_e                  next_pfx;

    fspr_sync #(.W(4), .INIT(4'he)) u_sync (
        .clk_in  (core_clk_in),
        .rstn_in (rstn_in),
        .d_in    ({cs_n_in, wp_n_in, pause_rst_n_in, frame_id}),
        .q_out   (sync_q)
    );

    wire  logic                 cs_s      = sync_q[3];
    wire  logic                 wp_s      = sync_q[2];
    wire  logic                 pr_s      = sync_q[1];
    wire  logic                 id_s      = sync_q[0];
    wire  logic                 frame_end = cs_s && !cs_prev && (id_s != seen_id);
    wire  logic [7:0]           cmd       = frame_byte[0];
    wire  logic [7:0]           b1        = frame_byte[1];
    wire  logic [7:0]           b2        = frame_byte[2];
    wire  logic [2:0]           nbytes    = bit_cnt[5:3];
    wire  logic                 aligned   = (bit_cnt[2:0] == 3'h0);
    wire  logic                 one_byte  = frame_end && aligned && (nbytes == 3'h1);
    wire  logic [2:0]           addr_b    = addr4 ? 3'h4 : 3'h3;
    wire  logic [BLOCK_W-1:0]   blk       = addr4 ? {b1[0], b2} : {1'b0, b1};
    wire  logic                 quad      = sr2_nv[SR2_QUAD];
    wire  logic                 busy      = op_running || (srw_cnt != 8'h00);
    wire  logic                 paused    = erase_paused || program_paused;
    wire  logic [4:0]           bp        = sr1_nv[SR1_GUARD_LSB +: 5];
    wire  logic                 inv       = sr2_nv[SR2_INVERT];
    wire  logic                 hit       = region_guarded(blk, bp, inv);
    wire  logic                 chip_ok   = (bp[2:0] == 3'h0 && !inv) || (bp[2:0] == 3'h7 && inv);
    wire  logic                 op_gate   = frame_end && aligned && latch && !busy && !paused;
    wire  logic                 hw_prot   = sr1_nv[SR1_LOCK_LO] && !wp_s && !quad;
    wire  logic                 sr_wr_ok  = latch && !busy && !otp_locked && !sr2_nv[SR2_LOCK_HI]
                                            && !hw_prot;
    wire  logic                 sr_wr_req = frame_end && aligned
                                            && ((cmd == CMD_STATUS_W12 && (nbytes == 3'h2 || nbytes == 3'h3))
                                            || ((cmd == CMD_STATUS_W2 || cmd == CMD_STATUS_W3) && nbytes == 3'h2));
    wire  logic                 sr_wr_go  = sr_wr_req && sr_wr_ok;
    wire  logic                 sr2_take  = (cmd == CMD_STATUS_W12 && nbytes == 3'h3) || (cmd == CMD_STATUS_W2);
    wire  logic [7:0]           sr2_src   = (cmd == CMD_STATUS_W12) ? b2 : b1;
    wire  logic [7:0]           sr2_new   = (sr2_nv & ~SR2_WMASK) | (sr2_src & SR2_WMASK) | (sr2_nv & SR2_OTP);
    wire  logic                 prog_req  = op_gate && cmd == CMD_PAGE_WRITE && nbytes >= addr_b + 3'h2;
    wire  logic                 sect_req  = op_gate && (cmd == CMD_SMALL_WIPE || cmd == CMD_LARGE_WIPE)
                                            && nbytes == addr_b + 3'h1;
    wire  logic                 prog_go   = prog_req && !hit;
    wire  logic                 sect_go   = sect_req && !hit;
    wire  logic                 chip_go   = op_gate && nbytes == 3'h1 && chip_ok
                                            && (cmd == CMD_CHIP_WIPE || cmd == CMD_CHIP_WIPE_B);
    wire  logic                 start_go  = prog_go || sect_go || chip_go;
    wire  logic                 susp_go   = one_byte && cmd == CMD_PAUSE && op_running;
    wire  logic                 resume_go = one_byte && cmd == CMD_CONTINUE && paused && !busy;
    wire  logic                 clr_go    = one_byte && cmd == CMD_CLEAR_FLAGS;
    wire  logic                 op_end    = array_done_in && op_running;
    wire  logic                 pin_rst   = sr3_nv[SR3_PIN_SEL] && !quad;
    wire  logic                 hw_fire   = pin_rst && !pr_s && (rst_cnt == 4'(RESET_LOW_CYCLES - 1));
    wire  logic                 sw_fire   = one_byte && cmd == CMD_RST_GO && pfx == PFX_66;
    wire  logic                 vol_rst   = hw_fire || sw_fire;
    wire  fspr_op_e             start_op  = prog_go ? OP_PROG : chip_go ? OP_CHIP
                                            : (cmd == CMD_SMALL_WIPE) ? OP_SMALL : OP_LARGE;
    wire  logic [7:0]           sr1_view  = sr1_nv | {6'h00, latch, busy};
    wire  logic [7:0]           sr2_view  = sr2_nv | {erase_paused, 3'h0, addr4, program_paused, 2'h0};
    wire  logic [7:0]           sr3_view  = sr3_nv | {4'h0, erase_fail, prog_fail, 2'h0};

    always_comb begin
        case (cmd)
            CMD_OTP_PFX1: next_pfx = PFX_AA;
            CMD_OTP_PFX2: next_pfx = (pfx == PFX_AA) ? PFX_55 : PFX_IDLE;
            CMD_RST_ARM:  next_pfx = PFX_66;
            default:      next_pfx = PFX_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            link_clr <= 1'b1;
            cs_prev  <= 1'b1;
            seen_id  <= 1'b0;
            pfx      <= PFX_IDLE;
        end else begin
            link_clr <= 1'b0;
            cs_prev  <= cs_s;
            if (frame_end) seen_id <= id_s;
            if (vol_rst)        pfx <= PFX_IDLE;
            else if (frame_end) pfx <= next_pfx;
        end
    end

    // Non-volatile bits; a real part keeps them in the array, here power-on resets them
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            sr1_nv     <= SR1_RESET;
            sr2_nv     <= SR2_RESET;
            sr3_nv     <= SR3_RESET;
            otp_locked <= 1'b0;
        end else begin
            if (sr_wr_go && cmd == CMD_STATUS_W12) sr1_nv <= b1 & SR1_WMASK;
            if (sr_wr_go && sr2_take)              sr2_nv <= sr2_new;
            if (sr_wr_go && cmd == CMD_STATUS_W3)  sr3_nv <= b1 & SR3_WMASK;
            if (sr_wr_go && pfx == PFX_55)         otp_locked <= 1'b1;
            if (vol_rst)                           sr2_nv[SR2_LOCK_HI] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in || vol_rst) begin
            latch <= 1'b0;
        end else if (one_byte && cmd == CMD_LATCH_SET) begin
            latch <= 1'b1;
        end else if ((one_byte && cmd == CMD_LATCH_CLR) || sr_wr_go || start_go || prog_req || sect_req) begin
            latch <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in || vol_rst) begin
            op_running <= 1'b0;
            cur_op     <= OP_NONE;
            srw_cnt    <= 8'h00;
        end else begin
            if (start_go) begin
                op_running <= 1'b1;
                cur_op     <= start_op;
            end else if (susp_go || op_end) begin
                op_running <= 1'b0;
            end else if (resume_go) begin
                op_running <= 1'b1;
            end
            if (sr_wr_go)               srw_cnt <= 8'(SR_WRITE_CYCLES);
            else if (srw_cnt != 8'h00)  srw_cnt <= srw_cnt - 8'h01;
        end
    end

    // Set terms sit last so an event in the clearing cycle wins
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in || vol_rst) begin
            erase_paused   <= 1'b0;
            program_paused <= 1'b0;
            prog_fail      <= 1'b0;
            erase_fail     <= 1'b0;
        end else begin
            if (resume_go) begin
                erase_paused   <= 1'b0;
                program_paused <= 1'b0;
            end
            if (susp_go && cur_op == OP_PROG) program_paused <= 1'b1;
            if (susp_go && cur_op != OP_PROG) erase_paused   <= 1'b1;
            if (clr_go || (resume_go && program_paused)) prog_fail <= 1'b0;
            if (clr_go || (resume_go && erase_paused))   erase_fail <= 1'b0;
            if ((prog_req && hit) || (op_end && array_fail_in && cur_op == OP_PROG)) begin
                prog_fail <= 1'b1;
            end
            if ((sect_req && hit) || (op_end && array_fail_in && cur_op != OP_PROG)) begin
                erase_fail <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in)                                 addr4 <= 1'b0;
        else if (vol_rst)                             addr4 <= sr3_nv[SR3_PU_ADDR];
        else if (one_byte && cmd == CMD_ADDR4_ENTER)  addr4 <= 1'b1;
        else if (one_byte && cmd == CMD_ADDR4_EXIT)   addr4 <= 1'b0;
    end

    // Pin must stay low for the whole window; a shorter glitch restarts the count
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in || !pin_rst || pr_s)                  rst_cnt <= 4'h0;
        else if (rst_cnt != 4'(RESET_LOW_CYCLES))          rst_cnt <= rst_cnt + 4'h1;
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            array_cmd_out <= '{valid: 1'b0, op: OP_NONE, block: '0};
        end else if (vol_rst) begin
            array_cmd_out <= '{valid: 1'b1, op: OP_ABORT, block: '0};
        end else if (start_go) begin
            array_cmd_out <= '{valid: 1'b1, op: start_op, block: blk};
        end else if (susp_go || resume_go) begin
            array_cmd_out <= '{valid: 1'b1, op: susp_go ? OP_SUSPEND : OP_RESUME, block: '0};
        end else begin
            array_cmd_out <= '{valid: 1'b0, op: OP_NONE, block: '0};
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            stat_pub            <= {SR3_RESET, SR2_RESET, SR1_RESET};
            busy_flag_out       <= 1'b0;
            quad_lines_on_out   <= 1'b0;
            pause_active_out    <= 1'b0;
            dummy_quad_out      <= 4'h6;
            dummy_dtr_out       <= 4'ha;
            out_strength_out    <= SR3_RESET[SR3_DRV_LSB +: 2];
            addr_width_flag_out <= 1'b0;
            secreg_locked_out   <= 2'h0;
        end else begin
            stat_pub            <= {sr3_view, sr2_view, sr1_view};
            busy_flag_out       <= busy;
            quad_lines_on_out   <= quad;
            pause_active_out    <= !sr3_nv[SR3_PIN_SEL] && !quad && !pr_s;
            dummy_quad_out      <= dummy_cycles(sr3_nv[SR3_DUMMY_LSB +: 2], 1'b0);
            dummy_dtr_out       <= dummy_cycles(sr3_nv[SR3_DUMMY_LSB +: 2], 1'b1);
            out_strength_out    <= sr3_nv[SR3_DRV_LSB +: 2];
            addr_width_flag_out <= addr4;
            secreg_locked_out   <= {sr2_nv[SR2_SEC_HI], sr2_nv[SR2_SEC_LO]};
        end
    end

endmodule // fspr_regs

// file: fspr_monitor.sv
module fspr_monitor import fspr_pkg::*; (
    input wire logic        core_clk_in,
    input wire logic        rstn_in,
    input fspr_array_cmd_s  array_cmd_out,
    input wire logic        busy_flag_out,
    input wire logic        quad_lines_on_out,
    input wire logic        pause_active_out,
    input wire logic [3:0]  dummy_quad_out,
    input wire logic [3:0]  dummy_dtr_out,
    input wire logic [1:0]  secreg_locked_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    chk_reset_dummy: assert property ($rose(rstn_in) |-> dummy_quad_out == 4'h6 && dummy_dtr_out == 4'ha)
        else $error("dummy reset value");
    chk_cmd_pulse: assert property (array_cmd_out.valid |=> !array_cmd_out.valid) else $error("cmd too long");
    chk_busy_start: assert property (array_cmd_out.valid && array_cmd_out.op inside {OP_PROG, OP_SMALL, OP_LARGE,
        OP_CHIP} |=> busy_flag_out) else $error("busy not set");
    chk_abort_idle: assert property (array_cmd_out.valid && array_cmd_out.op == OP_ABORT |-> ##[1:3]
        !busy_flag_out) else $error("busy after reset");
    chk_dummy_pair: assert property (dummy_dtr_out == 4'h8 |-> dummy_quad_out == 4'h6) else $error("dummy pair");
    chk_dummy_top: assert property (dummy_quad_out != 4'h6 |-> dummy_dtr_out == 4'ha) else $error("dummy top");
    chk_dummy_set: assert property (dummy_quad_out inside {4'h6, 4'h8, 4'ha} && dummy_dtr_out inside {4'h8, 4'ha})
        else $error("dummy value");
    chk_quad_pins: assert property (quad_lines_on_out && $past(quad_lines_on_out) |-> !pause_active_out)
        else $error("pause in quad");
    chk_secreg_once: assert property (($past(secreg_locked_out) & ~secreg_locked_out) == 2'b00)
        else $error("lock cleared");
endmodule // fspr_monitor

// file: fspr_host.sv
module fspr_host (
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      si_out,
    input wire logic  so_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end
    // Clock stands low between frames; gap covers the core's capture time
    task automatic xfer(input int n, input logic [47:0] d, output logic [7:0] r);
        cs_n_out = 1'b0;
        for (int i = 0; i < n * 8; i++) begin
            si_out = d[47-i];
            #16 sclk_out = 1'b1;
            r = {r[6:0], so_in};
            #16 sclk_out = 1'b0;
        end
        #16 cs_n_out = 1'b1;
        si_out = ~si_out;
        #600;
    endtask
endmodule // fspr_host

// file: flash_status_protect_regs_bench.sv
module flash_status_protect_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import fspr_pkg::*;
    logic core_clk_in = 0, rstn_in = 0, wp_n_in = 1, pause_rst_n_in = 1, array_done_in = 0, array_fail_in = 0;
    logic sclk_in, cs_n_in, si_in, so_out, so_oe_out, busy_flag_out, quad_lines_on_out, pause_active_out;
    logic addr_width_flag_out;
    logic [3:0] dummy_quad_out, dummy_dtr_out;
    logic [1:0] out_strength_out, secreg_locked_out;
    fspr_array_cmd_s array_cmd_out, got;
    logic [7:0] m[3], rd, x;
    logic [23:0] a;
    logic [7:0] rc[3] = '{CMD_READ_SR1, CMD_READ_SR2, CMD_READ_SR3};
    logic [3:0] dq[4] = '{4'h6, 4'h6, 4'h8, 4'ha};
    logic [3:0] dd[4] = '{4'ha, 4'h8, 4'ha, 4'ha};
    int n_mismatch = 0, n_tests = 0;
    fspr_regs i_dut (.core_clk_in, .rstn_in, .sclk_in, .cs_n_in, .si_in, .wp_n_in, .pause_rst_n_in, .array_done_in,
        .array_fail_in, .so_out, .so_oe_out, .array_cmd_out, .busy_flag_out, .quad_lines_on_out, .pause_active_out,
        .dummy_quad_out, .dummy_dtr_out, .out_strength_out, .addr_width_flag_out, .secreg_locked_out);
    fspr_host i_host (.sclk_out(sclk_in), .cs_n_out(cs_n_in), .si_out(si_in), .so_in(so_out));
    always #50 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) if (array_cmd_out.valid === 1'b1) got <= array_cmd_out;
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic fr(input int n, input logic [7:0] c, input logic [39:0] d);
        i_host.xfer(n, {c, d}, rd);
    endtask
    task automatic settle(input logic b);
        int n;
        repeat (6) @(posedge core_clk_in);
        #5 chk("busy", busy_flag_out, b);
        for (n = 0; n < 99 && busy_flag_out !== 1'b0; n++) begin
            @(posedge core_clk_in);
            #5;
        end
    endtask
    // Whole read-back of all three registers against the model m after selected steps
    task automatic rdall;
        for (int k = 0; k < 3; k++) begin
            i_host.xfer(2, {rc[k], 40'h0}, rd);
            chk("status", rd, m[k]);
        end
        $display("test done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #2ms;
        n_mismatch++;
        conclude();
    end
    initial begin
        void'($urandom(32'h71808b3c));
        repeat (2) @(posedge core_clk_in);
        #5 rstn_in = 1'b1;
        repeat (3) @(posedge core_clk_in);
        m = '{8'h00, 8'h00, 8'h20};
        rdall;
        chk("drive", out_strength_out, 2'h1);
        chk("oe", so_oe_out, 1'b0);
        chk("addr", addr_width_flag_out, 1'b0);
        x = 8'($urandom);
        fr(3, CMD_STATUS_W12, {x, 32'h0});
        settle(1'b0);
        fr(1, CMD_LATCH_SET, 40'h0);
        m[0] = 8'h02;
        rdall;
        x = 8'($urandom) | 8'h83;
        fr(3, CMD_STATUS_W12, {x, 32'h0});
        settle(1'b1);
        m[0] = x & SR1_WMASK;
        rdall;
        @(posedge core_clk_in) #5 wp_n_in = 1'b0;
        fr(1, CMD_LATCH_SET, 40'h0);
        fr(3, CMD_STATUS_W12, 40'h0);
        settle(1'b0);
        fr(1, CMD_LATCH_CLR, 40'h0);
        rdall;
        @(posedge core_clk_in) #5 wp_n_in = 1'b1;
        fr(1, CMD_LATCH_SET, 40'h0);
        fr(3, CMD_STATUS_W12, 40'h0);
        settle(1'b1);
        m[0] = 8'h00;
        rdall;
        for (int dc = 0; dc < 4; dc++) begin
            fr(1, CMD_LATCH_SET, 40'h0);
            fr(2, CMD_STATUS_W3, {8'h20 | 8'(dc), 32'h0});
            settle(1'b1);
            m[2] = 8'h20 | 8'(dc);
            chk("dquad", dummy_quad_out, dq[dc]);
            chk("ddtr", dummy_dtr_out, dd[dc]);
            rdall;
        end
        a = 24'($urandom);
        fr(1, CMD_LATCH_SET, 40'h0);
        fr(5, CMD_PAGE_WRITE, {a, 16'h5a00});
        settle(1'b1);
        chk("op", got.op, OP_PROG);
        chk("block", got.block, {1'b0, a[23:16]});
        fr(1, CMD_PAUSE, 40'h0);
        i_host.xfer(2, {CMD_READ_SR2, 40'h0}, rd);
        chk("paused", rd, 8'h04);
        fr(1, CMD_RST_ARM, 40'h0);
        fr(1, CMD_RST_GO, 40'h0);
        settle(1'b0);
        chk("op", got.op, OP_ABORT);
        m[0] = 8'h00;
        m[1] = 8'h00;
        rdall;
        fr(1, CMD_LATCH_SET, 40'h0);
        fr(4, CMD_LARGE_WIPE, {a, 16'h0});
        chk("op", got.op, OP_LARGE);
        @(posedge core_clk_in) #5 {array_done_in, array_fail_in} = 2'b11;
        @(posedge core_clk_in) #5 {array_done_in, array_fail_in} = 2'b00;
        m[2] = m[2] | 8'h08;
        rdall;
        fr(1, CMD_CLEAR_FLAGS, 40'h0);
        m[2] = m[2] & 8'hf7;
        rdall;
        fr(1, CMD_ADDR4_ENTER, 40'h0);
        chk("addr", addr_width_flag_out, 1'b1);
        @(posedge core_clk_in) #5 pause_rst_n_in = 1'b0;
        repeat (4) @(posedge core_clk_in);
        #5 chk("pause", pause_active_out, 1'b1);
        fr(1, CMD_LATCH_SET, 40'h0);
        fr(2, CMD_STATUS_W2, {8'h12, 32'h0});
        settle(1'b1);
        chk("quad", quad_lines_on_out, 1'b1);
        chk("pause", pause_active_out, 1'b0);
        chk("seclock", secreg_locked_out, 2'h1);
        fr(1, CMD_LATCH_SET, 40'h0);
        fr(2, CMD_STATUS_W2, {8'h00, 32'h0});
        settle(1'b1);
        chk("seclock", secreg_locked_out, 2'h1);
        chk("pause", pause_active_out, 1'b1);
        @(posedge core_clk_in) #5 pause_rst_n_in = 1'b1;
        m[1] = 8'h18;
        rdall;
        conclude();
    end
endmodule // flash_status_protect_regs_bench
bind fspr_regs fspr_monitor i_mon (.core_clk_in, .rstn_in, .array_cmd_out, .busy_flag_out, .quad_lines_on_out,
    .pause_active_out, .dummy_quad_out, .dummy_dtr_out, .secreg_locked_out);
